// >>> design/kil_pkg.sv
/*
 * shared constants, field layout, opcodes and carrier types of the
 * keyset interface logic.
 * assumes a 100 MHz hclk and a 10 ms tick from the maintenance panel logic.
 */
package kil_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_PERIOD_MS = 10;
   localparam int unsigned BOUNCE_MS = 10;
   // samples that must agree so that a bounce window is spanned
   localparam int unsigned STABLE_SAMPLES = BOUNCE_MS / TICK_PERIOD_MS + 1;

   // ==========================================================
   // output word from the digital output mux (written by software)
   localparam int unsigned PAY_LSB = 0;
   localparam int unsigned PAY_W = 4;
   localparam int unsigned LOOP_BIT = 4;
   localparam int unsigned OP_LSB = 5;
   localparam int unsigned OP_W = 4;
   localparam int unsigned NUM_OPS = 16;

   typedef enum logic [3:0] {
      OP_MATRIX = 4'h0,
      OP_PRO1   = 4'h1,
      OP_PRO7   = 4'h7,
      OP_PRO8   = 4'h8,
      OP_PRO9   = 4'h9,
      OP_MONO_A = 4'ha,
      OP_MONO_B = 4'hb,
      OP_MBG_A  = 4'hc,
      OP_MBG_B  = 4'hd,
      OP_CLR789 = 4'he,
      OP_SPARE  = 4'hf
   } kil_op_t;

   typedef struct packed {
      logic [3:0] op;
      logic loop_en;
      logic [3:0] payload;
   } kil_cmd_t;

   // ==========================================================
   // input word to the digital input mux
   localparam int unsigned IN_W = 8;
   localparam int unsigned IN_TEST_BIT = 7;
   localparam int unsigned SW_CODE_W = 6;
   localparam int unsigned NUM_SW = 37;
   localparam int unsigned NUM_PRO = 9;
   localparam int unsigned NUM_LIT = 8;

   typedef struct packed {
      logic [3:0] matrix_sel;
      logic [NUM_LIT-1:0] mono_lit;
      logic [NUM_LIT-1:0] matrix_lit;
      logic [NUM_PRO-1:0][3:0] pro_code;
   } kil_panel_t;

   // ==========================================================
   // register map (byte addresses) and reset values
   localparam logic [7:0] ADDR_OUTWORD = 8'h00;
   localparam logic [7:0] ADDR_INWORD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [4:0] STOR_RESET = 5'h00;
   localparam logic [7:0] INWORD_RESET = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage : kil_pkg

// >>> design/kil_decode.sv
/*
 * decodes one output word into storage write enables.
 * assumes a word already split into the kil_cmd_t fields.
 */
`timescale 1ns/1ns
module kil_decode (
   input wire kil_pkg::kil_cmd_t cmd,        // decoded output word
   input wire logic wr,                      // word is being applied
   output logic [kil_pkg::NUM_OPS-1:0] wr_sel, // entry to load
   output logic clr_789                      // clear readouts 7..9
);
   import kil_pkg::*;

   // every opcode owns one storage entry; its loop bit lives there too
   assign wr_sel = wr ? (16'h0001 << cmd.op) : 16'h0000;
   assign clr_789 = wr && (cmd.op == OP_CLR789);

endmodule : kil_decode

// >>> design/kil_debounce.sv
/*
 * qualifies keyset switch presses on the 10 ms tick and encodes them.
 * assumes inputs already synchronised to hclk and tick a 1-cycle pulse.
 */
`timescale 1ns/1ns
module kil_debounce #(
   parameter int unsigned NSW = kil_pkg::NUM_SW,
   parameter int unsigned NSTABLE = kil_pkg::STABLE_SAMPLES
) (
   input wire logic hclk,                    // system clock
   input wire logic hresetn,                 // async reset, low
   input wire logic tick,                    // 10 ms sample enable
   input wire logic common_n,                // switch common, low=pressed
   input wire logic [NSW-1:0] sw,            // switch lines, high=pressed
   output logic press,                       // one-cycle accepted press
   output logic [kil_pkg::SW_CODE_W-1:0] code // switch number
);
   import kil_pkg::*;

   typedef enum logic [1:0] {
      KIL_WAIT_REL = 2'b00,
      KIL_ARMED    = 2'b01,
      KIL_HELD     = 2'b10
   } kil_db_t;

   kil_db_t state;
   logic [NSW:0] last;
   logic [3:0] same;

   function automatic logic [SW_CODE_W-1:0] enc(input logic [NSW-1:0] v);
      logic [SW_CODE_W-1:0] r;
      r = '0;
      for (int i = 0; i < NSW; i++) begin
         if (v[i]) begin
            r = SW_CODE_W'(i);
         end
      end
      return enc_ret(r);
   endfunction : enc

   function automatic logic [SW_CODE_W-1:0] enc_ret(
      input logic [SW_CODE_W-1:0] r);
      return r;
   endfunction : enc_ret

   wire [NSW:0] sample = {common_n, sw};
   wire stable = (same >= 4'(NSTABLE - 1));
   wire released = common_n && (sw == '0);
   // two lines at once is not a legal press and is never encoded
   wire one_hot = (sw != '0) && ((sw & (sw - 1'b1)) == '0);
   wire pressed = !common_n && one_hot;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= KIL_WAIT_REL;
         last <= '0;
         same <= 4'h0;
         press <= 1'b0;
         code <= '0;
      end else begin
         press <= 1'b0;
         if (tick) begin
            last <= sample;
            same <= (sample == last) ? ((same == 4'hf) ? same : same + 4'h1)
                                     : 4'h0;
            case (state)
               KIL_WAIT_REL: begin
                  if (stable && released) begin
                     state <= KIL_ARMED;
                  end
               end
               KIL_ARMED: begin
                  if (stable && pressed && sample == last) begin
                     press <= 1'b1;
                     code <= enc(sw);
                     state <= KIL_HELD;
                  end
               end
               KIL_HELD: begin
                  if (stable && released && sample == last) begin
                     state <= KIL_ARMED;
                  end
               end
               default: state <= KIL_WAIT_REL;
            endcase
         end
      end
   end

endmodule : kil_debounce

// >>> design/kil_top.sv
/*
 * keyset interface logic: AHB-Lite slave standing for the digital
 * output and input multiplexers, decode and storage of output words,
 * panel drive lines, test loops and switch press reporting.
 * assumes a 100 MHz hclk, one AHB-Lite master, keyset lines and the
 * 10 ms clock arriving asynchronously from outside.
 */
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module kil_top (
   input wire logic hclk,                          // 100 MHz clock
   input wire logic hresetn,                       // async reset, low
   input wire logic hsel,                          // slave select
   input wire logic [31:0] haddr,                  // byte address
   input wire logic [1:0] htrans,                  // transfer type
   input wire logic hwrite,                        // write when high
   input wire logic [2:0] hsize,                   // transfer size
   input wire logic [31:0] hwdata,                 // write data
   input wire logic hready,                        // bus ready
   output logic hreadyout,                         // slave ready
   output logic hresp,                             // always okay
   output logic [31:0] hrdata,                     // read data
   input wire logic tick_10ms,                     // maintenance clock
   input wire logic switch_common_n,               // low while pressed
   input wire logic [kil_pkg::NUM_SW-1:0] switch_in, // keyset lines
   output kil_pkg::kil_panel_t panel,              // readout and lamps
   output logic [kil_pkg::IN_W-1:0] din_word,      // word to input mux
   output logic data_pending                       // word waiting
);
   import kil_pkg::*;

   // ==========================================================
   // synchronisers for everything arriving from the keyset side
   logic [NUM_SW+1:0] sync1;
   logic [NUM_SW+1:0] sync2;
   logic tick_d;

   // common resets to its idle level, so reset shows no press
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= {1'b0, 1'b1, {NUM_SW{1'b0}}};
         sync2 <= {1'b0, 1'b1, {NUM_SW{1'b0}}};
         tick_d <= 1'b0;
      end else begin
         sync1 <= {tick_10ms, switch_common_n, switch_in};
         sync2 <= sync1;
         tick_d <= sync2[NUM_SW+1];
      end
   end

   // the tick is asynchronous too; its edge is taken after the flops
   // one enable pulse per 10 ms period
   wire tick_en = sync2[NUM_SW+1] && !tick_d;
   wire common_s = sync2[NUM_SW];
   wire [NUM_SW-1:0] sw_s = sync2[NUM_SW-1:0];

   // ==========================================================
   // switch qualification
   wire press;
   wire [SW_CODE_W-1:0] press_code;

   kil_debounce #(
      .NSW(NUM_SW),
      .NSTABLE(STABLE_SAMPLES)
   ) u_debounce (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick_en),
      .common_n(common_s),
      .sw(sw_s),
      .press(press),
      .code(press_code)
   );

   // ==========================================================
   // AHB-Lite slave: address phase capture
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_addr;

   // only the low byte is decoded, so the map repeats every 256 bytes
   function automatic logic reg_hit(input logic [7:0] a,
         input logic [7:0] want);
      return a == want;
   endfunction : reg_hit

   wire ap_take = hsel && hready && htrans == HTRANS_NONSEQ;
   wire [7:0] ap_addr = haddr[7:0];
   wire ap_read = ap_take && !hwrite;
   wire ap_sel_out = reg_hit(ap_addr, ADDR_OUTWORD);
   wire ap_sel_in = reg_hit(ap_addr, ADDR_INWORD);
   wire ap_sel_status = reg_hit(ap_addr, ADDR_STATUS);
   wire rd_inword = ap_read && ap_sel_in;
   wire rd_status = ap_read && ap_sel_status;
   wire wr_outword = dp_valid && dp_write && reg_hit(dp_addr, ADDR_OUTWORD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_valid <= ap_take;
         dp_write <= hwrite;
         dp_addr <= ap_addr;
      end
   end

   // ==========================================================
   // AHB-Lite slave: response
   // every access is single-word and zero-wait, so hsize goes unread
   // and the answer is always ready and okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ==========================================================
   // output word decode and storage
   logic [4:0] stor [0:NUM_OPS-1];
   logic [NUM_OPS-1:0] wr_sel;
   logic clr_789;
   logic [OP_W-1:0] last_op;
   logic [31:0] last_cmd;

   // entry f drives no panel line; it only serves its test loop
   kil_cmd_t cmd;
   assign cmd.op = hwdata[OP_LSB +: OP_W];
   assign cmd.loop_en = hwdata[LOOP_BIT];
   assign cmd.payload = hwdata[PAY_LSB +: PAY_W];

   kil_decode u_decode (
      .cmd(cmd),
      .wr(wr_outword),
      .wr_sel(wr_sel),
      .clr_789(clr_789)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_OPS; i++) begin
            stor[i] <= STOR_RESET;
         end
      end else begin
         for (int i = 0; i < NUM_OPS; i++) begin
            if (wr_sel[i]) begin
               stor[i] <= {cmd.loop_en, cmd.payload};
            end
         end
         // clear keeps the loop bits of readouts 7 to 9
         if (clr_789) begin
            stor[OP_PRO7][3:0] <= 4'h0;
            stor[OP_PRO8][3:0] <= 4'h0;
            stor[OP_PRO9][3:0] <= 4'h0;
            stor[OP_CLR789] <= {cmd.loop_en, 4'h0};
         end
      end
   end

   // read back of the last output word, for software's own checks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_cmd <= 32'h0000_0000;
      end else if (wr_outword) begin
         last_cmd <= hwdata;
      end
   end

   // ==========================================================
   // panel drive lines, straight from the storage flops
   assign panel.matrix_sel = stor[OP_MATRIX][3:0];
   assign panel.mono_lit = {stor[OP_MONO_B][3:0],
                            stor[OP_MONO_A][3:0]};
   assign panel.matrix_lit = {stor[OP_MBG_B][3:0],
                              stor[OP_MBG_A][3:0]};

   // readout n lives in entry n; entry 0 holds the matrix code
   for (genvar g = 0; g < NUM_PRO; g++) begin : g_pro
      assign panel.pro_code[g] = stor[g + 1][3:0];
   end

   logic [NUM_OPS-1:0] loop_on;
   for (genvar g = 0; g < NUM_OPS; g++) begin : g_loop
      assign loop_on[g] = stor[g][4];
   end

   // ==========================================================
   // test loop echo: an enabled loop reads its entry back
   logic echo_req;
   wire echo_load;
   wire echo_drop;

   // the echo waits behind a pending word instead of overwriting it
   wire echo_start = wr_outword && cmd.loop_en;
   // the entry is read a cycle after the write, once it has landed
   wire [4:0] echo_data = stor[last_op];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         echo_req <= 1'b0;
         last_op <= '0;
      end else if (echo_start) begin
         echo_req <= 1'b1;
         last_op <= cmd.op;
      end else if (echo_load || echo_drop) begin
         // a loop switched off before its echo left sends nothing
         echo_req <= 1'b0;
      end
   end

   // ==========================================================
   // input word holding register toward the input mux
   logic overrun;

   wire hold_free = !data_pending || rd_inword;
   // a real press has priority over an echo in the same cycle
   wire press_load = press && hold_free;
   wire press_lost = press && !hold_free;
   assign echo_load = echo_req && hold_free && !press && loop_on[last_op];
   assign echo_drop = echo_req && !loop_on[last_op];
   wire [IN_W-1:0] press_word = {1'b0, 1'b0, press_code};
   wire [IN_W-1:0] echo_word = {1'b1, 1'b0, 1'b0, echo_data};
   wire [IN_W-1:0] next_din_word = press_load ? press_word : echo_word;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         din_word <= INWORD_RESET;
      end else if (press_load || echo_load) begin
         din_word <= next_din_word;
      end
   end

   // a new word in the cycle it is read keeps the strobe up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_pending <= 1'b0;
      end else if (press_load || echo_load) begin
         data_pending <= 1'b1;
      end else if (rd_inword) begin
         data_pending <= 1'b0;
      end
   end

   // a press that finds the register full is lost; only a flag says so
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun <= 1'b0;
      end else if (press_lost) begin
         overrun <= 1'b1;
      end else if (rd_status) begin
         overrun <= 1'b0;
      end
   end

   // ==========================================================
   // read data, registered at the address phase
   // loop enables sit in the top half, the flags in the bottom bits
   wire [31:0] status_word = {loop_on, 13'h0000, overrun, echo_req,
                              data_pending};
   // unmapped offsets read as zero; writes to them are ignored
   wire [31:0] rd_mux =
      ap_sel_out ? last_cmd :
      ap_sel_in ? {24'h000000, din_word} :
      ap_sel_status ? status_word : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_read) begin
         hrdata <= rd_mux;
      end
   end

endmodule : kil_top

// >>> dv/kil_props.sv
/* assertions on the kil_top ports, bound at the foot of this file.
   assumes hready comes from hreadyout and one bus master. */
`timescale 1ns/1ns
module kil_props (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, low
   input wire logic hsel, // select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic [31:0] hrdata, // read data
   input wire logic tick_10ms, // tick
   input wire logic switch_common_n, // common
   input wire logic [kil_pkg::NUM_SW-1:0] switch_in, // switches
   input wire kil_pkg::kil_panel_t panel, // panel lines
   input wire logic [kil_pkg::IN_W-1:0] din_word, // input word
   input wire logic data_pending // pending
);
   import kil_pkg::*;
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ====================
   // bus phases
   wire take = hsel && hready && htrans == HTRANS_NONSEQ;
   wire rd_in = take && !hwrite && haddr[7:0] == ADDR_INWORD;
   wire rd_bad = take && !hwrite && haddr[7:0] > ADDR_STATUS;
   logic wr_d;
   logic wr_dd;
   kil_cmd_t c;
   // the word lands on the data-phase edge, so catch it there
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_d <= 1'b0;
         wr_dd <= 1'b0;
         c <= '0;
      end else begin
         wr_d <= take && hwrite && haddr[7:0] == ADDR_OUTWORD;
         wr_dd <= wr_d;
         c <= wr_d ? hwdata[8:0] : c;
      end
   end
   // ====================
   // assertions
   a_okay_ready: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_pend_hold: assert property (data_pending && !rd_in |=> data_pending)
      else $error("pending dropped without a read");
   a_word_held: assert property (data_pending && !rd_in |=> $stable(din_word))
      else $error("waiting word changed");
   a_word_form: assert property ($rose(data_pending) |->
      (din_word[7] ? din_word[6:5] == 2'b00 : din_word[6] == 1'b0))
      else $error("input word layout wrong");
   a_inword_read: assert property (rd_in |=> hrdata == {24'h0, $past(din_word)})
      else $error("input word read wrong");
   a_unmapped_zero: assert property (rd_bad |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_pro_store: assert property (wr_dd && c.op >= 4'h1 && c.op <= 4'h9 |->
      panel.pro_code[c.op - 4'h1] == c.payload)
      else $error("readout code not stored");
   a_matrix_store: assert property (wr_dd && c.op == OP_MATRIX |->
      panel.matrix_sel == c.payload)
      else $error("combination code not stored");
   a_mono_store: assert property (wr_dd && c.op[3:1] == 3'b101 |->
      (c.op[0] ? panel.mono_lit[7:4] : panel.mono_lit[3:0]) == c.payload)
      else $error("lamp group not stored");
   a_bg_store: assert property (wr_dd && c.op[3:1] == 3'b110 |->
      (c.op[0] ? panel.matrix_lit[7:4] : panel.matrix_lit[3:0]) == c.payload)
      else $error("background group not stored");
   a_clear_pro: assert property (wr_dd && c.op == OP_CLR789 |->
      panel.pro_code[8:6] == '0)
      else $error("readouts 7 to 9 not cleared");
   a_quiet_panel: assert property (!wr_dd |-> $stable(panel))
      else $error("panel changed without a write");
   c_press: cover property ($rose(data_pending) && !din_word[7]);
   c_echo: cover property ($rose(data_pending) && din_word[7]);
   c_clear: cover property (wr_dd && c.op == OP_CLR789);
endmodule : kil_props

bind kil_top kil_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
   .tick_10ms, .switch_common_n, .switch_in, .panel, .din_word,
   .data_pending);

// >>> dv/kil_keyset_model.sv
/* keyset and maintenance clock model: tick, switch lines, common.
   assumes the bench calls press from its own process. */
`timescale 1ns/1ns
module kil_keyset_model #(
   parameter int unsigned TICK_CYC = 40
) (
   input wire logic hclk, // clock
   output logic tick_10ms, // scaled tick
   output logic switch_common_n, // low while pressed
   output logic [kil_pkg::NUM_SW-1:0] switch_in // switch lines
);
   import kil_pkg::*;
   int cnt = 0;
   initial begin
      tick_10ms = 1'b0;
      switch_common_n = 1'b1;
      switch_in = '0;
   end
   // ====================
   // tick, scaled: a true 10 ms needs a million cycles
   always @(posedge hclk) begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      tick_10ms <= cnt < TICK_CYC / 2;
   end
   // ====================
   // bounce in, hold over 6 ticks, bounce out, stay released
   task automatic press(input logic [NUM_SW-1:0] m);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 7; i++) begin
            @(posedge hclk);
            switch_in <= (i[0] ^ p[0]) ? '0 : m;
            switch_common_n <= i[0] ^ p[0];
         end
         repeat (6 * TICK_CYC) @(posedge hclk);
      end
   endtask : press
endmodule : kil_keyset_model

// >>> dv/keyset_interface_logic_tb_top.sv
/* self-checking bench of the keyset interface logic.
   assumes the keyset model makes the tick and switch lines. */
`timescale 1ns/1ns
module keyset_interface_logic_tb_top;
   import kil_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata;
   wire tick_10ms;
   wire switch_common_n;
   wire [NUM_SW-1:0] switch_in;
   wire kil_panel_t panel;
   wire [IN_W-1:0] din_word;
   wire data_pending;
   int fails = 0;
   int num_checks = 0;
   int s;
   logic [31:0] lf = 32'h00015701; // seed 87809
   logic [63:0] exp_q[$];
   logic [63:0] e;
   kil_panel_t exp_p = '0;
   logic rd_dp = 1'b0;
   logic [3:0] eo[3] = '{4'h0, 4'h9, 4'he};
   always #5 hclk = ~hclk;
   kil_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tick_10ms,
      .switch_common_n, .switch_in, .panel, .din_word, .data_pending);
   kil_keyset_model km (.hclk, .tick_10ms, .switch_common_n, .switch_in);
   // ====================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic chk(input logic [31:0] g, input logic [31:0] x,
         input logic [31:0] m);
      num_checks++;
      if ((g & m) !== (x & m)) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic chk_panel();
      num_checks++;
      if (panel !== exp_p) begin
         fails++;
         $display("Error at %0t: panel %h expected %h", $time, panel, exp_p);
      end
   endtask : chk_panel
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      if (!w) exp_q.push_back({m, d});
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : ahb
   task automatic wr(input logic [3:0] op, input logic le, input logic [3:0] p);
      ahb(1'b1, ADDR_OUTWORD, {23'h0, op, le, p});
      case (op)
         4'h0: exp_p.matrix_sel = p;
         4'ha: exp_p.mono_lit[3:0] = p;
         4'hb: exp_p.mono_lit[7:4] = p;
         4'hc: exp_p.matrix_lit[3:0] = p;
         4'hd: exp_p.matrix_lit[7:4] = p;
         4'he: exp_p.pro_code[8:6] = '0;
         4'hf: ;
         default: exp_p.pro_code[op - 4'h1] = p;
      endcase
      @(posedge hclk);
      chk_panel();
   endtask : wr
   // ====================
   // read data monitor: oldest note against each completed read
   always @(posedge hclk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         e = exp_q.pop_front();
         chk(hrdata, e[31:0], e[63:32]);
      end
      rd_dp <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
   end
   // ====================
   // tests
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (120) @(posedge hclk);
      chk({31'h0, data_pending}, 32'h0, 32'h1);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      ahb(1'b0, ADDR_INWORD, 32'h0);
      ahb(1'b0, 8'h0c, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         lf = nxt(lf);
         wr(i[3:0], 1'b0, lf[3:0]);
      end
      ahb(1'b0, ADDR_OUTWORD, {23'h0, 4'hf, 1'b0, lf[3:0]}, 32'h1ff);
      $display("test store done");
      for (int k = 0; k < 3; k++) begin
         lf = nxt(lf);
         wr(eo[k], 1'b1, lf[3:0]);
         ahb(1'b0, ADDR_STATUS, 32'h1 << (16 + eo[k]), 32'hffff0000);
         while (data_pending !== 1'b1) @(posedge hclk);
         // an echo queued behind a waiting word is dropped with its loop
         wr(4'h1, 1'b1, lf[7:4]);
         wr(4'h1, 1'b0, lf[7:4]);
         ahb(1'b0, ADDR_STATUS, 32'h1, 32'h3);
         ahb(1'b0, ADDR_INWORD,
            {24'h0, 4'h9, eo[k] == 4'he ? 4'h0 : lf[3:0]});
         wr(eo[k], 1'b0, lf[3:0]);
      end
      repeat (160) @(posedge hclk);
      chk({31'h0, data_pending}, 32'h0, 32'h1);
      ahb(1'b0, ADDR_STATUS, 32'h0, 32'hffff0002);
      $display("test loop done");
      for (int k = 0; k < 3; k++) begin
         lf = nxt(lf);
         s = k == 0 ? 0 : k == 1 ? 36 : int'(lf % 37);
         km.press(NUM_SW'(1) << s);
         chk({31'h0, data_pending}, 32'h1, 32'h1);
         ahb(1'b0, ADDR_INWORD, 32'(s));
         ahb(1'b0, ADDR_STATUS, 32'h0, 32'h5);
      end
      km.press(NUM_SW'(1) << 3 | NUM_SW'(1) << 7);
      chk({31'h0, data_pending}, 32'h0, 32'h1);
      $display("test press done");
      // second press is lost while the first waits unread
      km.press(NUM_SW'(1) << 4);
      km.press(NUM_SW'(1) << 9);
      ahb(1'b0, ADDR_INWORD, 32'h4);
      ahb(1'b0, ADDR_STATUS, 32'h4, 32'h5);
      ahb(1'b0, ADDR_STATUS, 32'h0, 32'h5);
      $display("test overrun done");
      finish_test();
   end
   // about 3400 cycles of tests, so this is a hang
   initial begin
      repeat (40000) @(posedge hclk);
      fails++;
      finish_test();
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
endmodule : keyset_interface_logic_tb_top
